// File: pkg/pmbus_seq_pkg.sv
// Constants, types and decode helpers for the command register block.
// Assumes a 20 MHz i_mclk and a transport layer that presents decoded commands.
package pmbus_seq_pkg;
	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_IN_LOW_WARN = 8'h58;
	localparam logic [7:0] CMD_IN_LOW_FAULT = 8'h59;
	localparam logic [7:0] CMD_IN_LOW_ACTION = 8'h5a;
	localparam logic [7:0] CMD_GOOD_ON = 8'h5e;
	localparam logic [7:0] CMD_ON_DELAY = 8'h60;
	localparam logic [7:0] CMD_ON_RAMP = 8'h61;
	localparam logic [7:0] CMD_OFF_DELAY = 8'h64;
	localparam logic [7:0] CMD_OFF_RAMP = 8'h65;
	localparam logic [7:0] CMD_CRIT_SUMMARY = 8'h78;
	localparam logic [7:0] CMD_FULL_SUMMARY = 8'h79;
	localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7a;
	localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7b;
	localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7c;
	localparam logic [7:0] CMD_CML_FLAGS = 8'h7e;
	// ----------------------------------------------------------------
	// Reset values and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] ACTION_RST = 8'h80;
	localparam logic [1:0] ACTION_RSVD = 2'b10;
	localparam logic [2:0] RETRY_NONE = 3'b000;
	localparam logic [2:0] RETRY_ALWAYS = 3'b111;
	localparam logic [15:0] TIME_RST = 16'hca80;
	localparam int CML_BAD_WRITE = 1;
	localparam int CML_BAD_CMD = 7;
	localparam logic [1:0] STRAP_LOAD_AT = 2'd2;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int MCLK_HZ = 20_000_000;
	localparam int MS_CYCLES = MCLK_HZ / 1000;
	localparam int RETRY_STEP_MS = 35;
	localparam int ON_DELAY_MAX_MS = 500;
	localparam int ON_RAMP_MAX_MS = 200;
	localparam int OFF_DELAY_MAX_MS = 256;
	localparam int OFF_RAMP_MAX_MS = 200;
	localparam int WARN_NUM = 11;
	localparam int WARN_DEN = 10;
	localparam int GOOD_NUM = 9;
	localparam int GOOD_DEN = 10;
	// ----------------------------------------------------------------
	// Monitor pin indices
	// ----------------------------------------------------------------
	localparam int MON_W = 16;
	localparam int MON_OUTPUT_HIGH_FAULT_FLAG = 0;
	localparam int MON_VOUT_OV_WARN = 1;
	localparam int MON_VOUT_UV_WARN = 2;
	localparam int MON_VOUT_UV_FAULT = 3;
	localparam int MON_OUTPUT_OVERCURRENT_FAULT_FLAG = 4;
	localparam int MON_IOUT_OC_LV = 5;
	localparam int MON_IOUT_OC_WARN = 6;
	localparam int MON_IOUT_UC = 7;
	localparam int MON_VIN_OV_FAULT = 8;
	localparam int MON_VIN_OV_WARN = 9;
	localparam int MON_VIN_BELOW_WARN = 10;
	localparam int MON_VIN_BELOW_FAULT = 11;
	localparam int MON_TEMP = 12;
	localparam int MON_VENDOR = 13;
	localparam int MON_VOUT_ABOVE_GOOD = 14;
	localparam int MON_VOUT_BELOW_UVF = 15;

	typedef enum logic [2:0] {
		SEQ_OFF, SEQ_ON_DLY, SEQ_RISE, SEQ_ON, SEQ_OFF_DLY, SEQ_FALL, SEQ_HOLD, SEQ_RETRY
	} seq_state_t;

	// Linear-11 millisecond value to whole ms, clamped to lim
	function automatic logic [15:0] l11_ms(input logic [15:0] v, input int lim);
		logic signed [4:0] e;
		logic [31:0] r;
		e = v[15:11];
		r = {21'd0, v[10:0]};
		if (v[10]) begin
			r = '0;
		end else if (e < 0) begin
			r = r >> 5'(-e);
		end else begin
			r = r << e;
		end
		if (r > 32'(lim)) begin
			r = 32'(lim);
		end
		return r[15:0];
	endfunction
endpackage

// File: pkg/ms_timer_if.sv
// Millisecond timer link between the sequencer and its timer.
// Assumes both ends run on i_mclk.
`timescale 1ns/10ps
interface ms_timer_if;
	logic start;
	logic [15:0] ms;
	logic done;
	modport ctl(output start, output ms, input done);
	modport tmr(input start, input ms, output done);
endinterface

// File: design/seq_ms_timer.sv
// Millisecond down-counter; done pulses once when the loaded time expires.
// Assumes a synchronous start pulse on the same clock.
`timescale 1ns/10ps
module seq_ms_timer #(
	parameter int MS_CYCLES = pmbus_seq_pkg::MS_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	ms_timer_if.tmr t
);
	logic [31:0] cyc_q;
	logic [15:0] left_q;
	logic run_q;

	initial begin
		if (MS_CYCLES < 1) begin
			$error("MS_CYCLES must be at least 1");
		end
	end

	assign t.done = run_q && (left_q == 16'h0000);

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_q <= 1'b0;
			left_q <= '0;
			cyc_q <= '0;
		end else if (t.start) begin
			run_q <= 1'b1;
			left_q <= t.ms;
			cyc_q <= '0;
		end else if (run_q) begin
			if (left_q == 16'h0000) begin
				run_q <= 1'b0;
			end else if (cyc_q == 32'(MS_CYCLES - 1)) begin
				cyc_q <= '0;
				left_q <= left_q - 16'h0001;
			end else begin
				cyc_q <= cyc_q + 32'd1;
			end
		end
	end
endmodule

// File: design/pmbus_fault_status_sequencing_regs.sv
// Fault thresholds, power sequencing timers and status summary registers.
// Assumes a transport layer that decodes commands on i_mclk; monitor pins,
// the enable pin and straps are asynchronous and are synchronised here.
`timescale 1ns/10ps
// Contract
// (RULE1) Warn crossing sets summary, input flag, alert
// (RULE2) Fault held until input above warn
// (RULE3) Warn threshold R/W, default 1.1x strap
// (RULE4) Fault threshold R/W, default from strap
// (RULE5) Action reserved 10; retry 000 or 111
// (RULE6) Retry spacing is (delay+1) times 35 ms
// (RULE7) Action resets to 80h
// (RULE8) Good on above threshold, off below UVF
// (RULE9) Good threshold R/W, default 0.9x strap
// (RULE10) Turn-on delay before ramp, default 5 ms
// (RULE11) Ramp up over rise time, reset CA80h
// (RULE12) Turn-off delay before fall, default 5 ms
// (RULE13) Ramp down over fall time
// (RULE14) Status byte bit layout as listed
// (RULE15) Off bit set whenever output unpowered
// (RULE16) Status word: byte low, summaries high
// (RULE17) Word bit 11 set while good negated
// (RULE18) Host reads details guided by summaries
// (RULE19) Output voltage flags layout, low nibble zero
// (RULE20) Output current flags layout, low nibble zero
// (RULE21) Input flags layout, low nibble zero
// (RULE22) Write to read-only ignored, sets comm bit 1
// (RULE23) Details latch; summaries follow details
module pmbus_fault_status_sequencing_regs #(
	parameter int MS_CYCLES = pmbus_seq_pkg::MS_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_enable,
	input wire logic [15:0] i_monitor,
	input wire logic [15:0] i_strap_uv_fault,
	input wire logic [15:0] i_strap_vout,
	input wire logic [7:0] i_cmd,
	input wire logic i_wr,
	input wire logic [15:0] i_wdata,
	input wire logic i_rd,
	input wire logic i_clear_faults,
	output logic [15:0] o_rdata,
	output logic o_rd_valid,
	output logic o_power_stage_on,
	output logic o_ramp_up,
	output logic o_ramp_down,
	output logic o_power_good,
	output logic o_alert
);
	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [16:0] pin_s1_q, pin_s2_q;
	logic [31:0] strap_s1_q, strap_s2_q;
	logic [15:0] mon;
	logic en_s;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			strap_s1_q <= '0;
			strap_s2_q <= '0;
		end else begin
			pin_s1_q <= {i_enable, i_monitor};
			pin_s2_q <= pin_s1_q;
			strap_s1_q <= {i_strap_vout, i_strap_uv_fault};
			strap_s2_q <= strap_s1_q;
		end
	end
	assign mon = pin_s2_q[15:0];
	assign en_s = pin_s2_q[16];

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [15:0] warn_q, fault_q, good_on_q, on_dly_q, on_ramp_q, off_dly_q, off_ramp_q;
	logic [5:0] action_q;
	logic [1:0] load_cnt_q;
	logic [15:0] warn_dflt, good_dflt;
	logic signed [15:0] warn_mant;
	logic [31:0] good_full;
	logic wr_rw, wr_ro, wr_bad;
	localparam logic [5:0] ACTION_LOW = pmbus_seq_pkg::ACTION_RST[5:0]; // RULE7

	always_comb begin
		warn_mant = 16'(($signed({{5{strap_s2_q[10]}}, strap_s2_q[10:0]})
			* pmbus_seq_pkg::WARN_NUM) / pmbus_seq_pkg::WARN_DEN);
		warn_dflt = {strap_s2_q[15:11], warn_mant[10:0]};
		good_full = ({16'd0, strap_s2_q[31:16]} * 32'(pmbus_seq_pkg::GOOD_NUM))
			/ 32'(pmbus_seq_pkg::GOOD_DEN);
		good_dflt = good_full[15:0];
	end

	always_comb begin
		wr_rw = 1'b0;
		wr_ro = 1'b0;
		unique case (i_cmd)
			pmbus_seq_pkg::CMD_IN_LOW_WARN, pmbus_seq_pkg::CMD_IN_LOW_FAULT,
			pmbus_seq_pkg::CMD_IN_LOW_ACTION, pmbus_seq_pkg::CMD_GOOD_ON,
			pmbus_seq_pkg::CMD_ON_DELAY, pmbus_seq_pkg::CMD_ON_RAMP,
			pmbus_seq_pkg::CMD_OFF_DELAY, pmbus_seq_pkg::CMD_OFF_RAMP: begin
				wr_rw = i_wr;
			end
			pmbus_seq_pkg::CMD_CRIT_SUMMARY, pmbus_seq_pkg::CMD_FULL_SUMMARY,
			pmbus_seq_pkg::CMD_VOUT_FLAGS, pmbus_seq_pkg::CMD_IOUT_FLAGS,
			pmbus_seq_pkg::CMD_INPUT_FLAGS, pmbus_seq_pkg::CMD_CML_FLAGS: begin
				wr_ro = i_wr;
			end
			default: begin
			end
		endcase
		wr_bad = i_wr && !wr_rw && !wr_ro;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			load_cnt_q <= '0;
			warn_q <= '0;
			fault_q <= '0;
			good_on_q <= '0;
			action_q <= ACTION_LOW;
			on_dly_q <= pmbus_seq_pkg::TIME_RST; // RULE10
			on_ramp_q <= pmbus_seq_pkg::TIME_RST; // RULE11
			off_dly_q <= pmbus_seq_pkg::TIME_RST; // RULE12
			off_ramp_q <= pmbus_seq_pkg::TIME_RST;
		end else if (load_cnt_q == pmbus_seq_pkg::STRAP_LOAD_AT) begin
			load_cnt_q <= load_cnt_q + 2'd1;
			warn_q <= warn_dflt; // RULE3
			fault_q <= strap_s2_q[15:0]; // RULE4
			good_on_q <= good_dflt; // RULE9
		end else begin
			if (load_cnt_q < pmbus_seq_pkg::STRAP_LOAD_AT) begin
				load_cnt_q <= load_cnt_q + 2'd1;
			end
			if (wr_rw) begin
				unique case (i_cmd)
					pmbus_seq_pkg::CMD_IN_LOW_WARN: warn_q <= i_wdata; // RULE3
					pmbus_seq_pkg::CMD_IN_LOW_FAULT: fault_q <= i_wdata; // RULE4
					pmbus_seq_pkg::CMD_IN_LOW_ACTION: action_q <= i_wdata[5:0];
					pmbus_seq_pkg::CMD_GOOD_ON: good_on_q <= i_wdata; // RULE9
					pmbus_seq_pkg::CMD_ON_DELAY: on_dly_q <= i_wdata;
					pmbus_seq_pkg::CMD_ON_RAMP: on_ramp_q <= i_wdata;
					pmbus_seq_pkg::CMD_OFF_DELAY: off_dly_q <= i_wdata;
					default: off_ramp_q <= i_wdata;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Input undervoltage hold and power good
	// ----------------------------------------------------------------
	logic uv_hold_q, good_q;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			uv_hold_q <= 1'b0;
		end else if (mon[pmbus_seq_pkg::MON_VIN_BELOW_FAULT]) begin
			uv_hold_q <= 1'b1;
		end else if (!mon[pmbus_seq_pkg::MON_VIN_BELOW_WARN]) begin
			uv_hold_q <= 1'b0; // RULE2
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			good_q <= 1'b0;
		end else if (mon[pmbus_seq_pkg::MON_VOUT_BELOW_UVF]) begin
			good_q <= 1'b0; // RULE8
		end else if (mon[pmbus_seq_pkg::MON_VOUT_ABOVE_GOOD]) begin
			good_q <= 1'b1; // RULE8
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	pmbus_seq_pkg::seq_state_t st_q, st_d;
	ms_timer_if tmr();
	logic powered, uv_trip;

	seq_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.t(tmr.tmr)
	);

	assign uv_trip = mon[pmbus_seq_pkg::MON_VIN_BELOW_FAULT];

	always_comb begin
		st_d = st_q;
		tmr.start = 1'b0;
		tmr.ms = '0;
		if (uv_trip && st_q inside {pmbus_seq_pkg::SEQ_ON_DLY, pmbus_seq_pkg::SEQ_RISE,
			pmbus_seq_pkg::SEQ_ON, pmbus_seq_pkg::SEQ_OFF_DLY, pmbus_seq_pkg::SEQ_FALL}) begin
			if (action_q[5:3] == pmbus_seq_pkg::RETRY_ALWAYS) begin
				st_d = pmbus_seq_pkg::SEQ_RETRY; // RULE5
				tmr.start = 1'b1;
				tmr.ms = 16'(({13'd0, action_q[2:0]} + 16'd1)
					* 16'(pmbus_seq_pkg::RETRY_STEP_MS)); // RULE6
			end else begin
				st_d = pmbus_seq_pkg::SEQ_HOLD; // RULE5
			end
		end else begin
			unique case (st_q)
				pmbus_seq_pkg::SEQ_OFF: begin
					if (en_s && !uv_hold_q) begin
						st_d = pmbus_seq_pkg::SEQ_ON_DLY;
						tmr.start = 1'b1;
						tmr.ms = pmbus_seq_pkg::l11_ms(on_dly_q,
							pmbus_seq_pkg::ON_DELAY_MAX_MS); // RULE10
					end
				end
				pmbus_seq_pkg::SEQ_ON_DLY: begin
					if (!en_s) begin
						st_d = pmbus_seq_pkg::SEQ_OFF;
					end else if (tmr.done) begin
						st_d = pmbus_seq_pkg::SEQ_RISE;
						tmr.start = 1'b1;
						tmr.ms = pmbus_seq_pkg::l11_ms(on_ramp_q,
							pmbus_seq_pkg::ON_RAMP_MAX_MS); // RULE11
					end
				end
				pmbus_seq_pkg::SEQ_RISE: begin
					if (tmr.done) begin
						st_d = pmbus_seq_pkg::SEQ_ON;
					end
				end
				pmbus_seq_pkg::SEQ_ON: begin
					if (!en_s) begin
						st_d = pmbus_seq_pkg::SEQ_OFF_DLY;
						tmr.start = 1'b1;
						tmr.ms = pmbus_seq_pkg::l11_ms(off_dly_q,
							pmbus_seq_pkg::OFF_DELAY_MAX_MS); // RULE12
					end
				end
				pmbus_seq_pkg::SEQ_OFF_DLY: begin
					if (tmr.done) begin
						st_d = pmbus_seq_pkg::SEQ_FALL;
						tmr.start = 1'b1;
						tmr.ms = pmbus_seq_pkg::l11_ms(off_ramp_q,
							pmbus_seq_pkg::OFF_RAMP_MAX_MS); // RULE13
					end
				end
				pmbus_seq_pkg::SEQ_FALL: begin
					if (tmr.done) begin
						st_d = pmbus_seq_pkg::SEQ_OFF;
					end
				end
				pmbus_seq_pkg::SEQ_HOLD: begin
					if (!uv_hold_q) begin
						st_d = pmbus_seq_pkg::SEQ_OFF; // RULE5
					end
				end
				pmbus_seq_pkg::SEQ_RETRY: begin
					if (!en_s) begin
						st_d = pmbus_seq_pkg::SEQ_OFF;
					end else if (tmr.done) begin
						st_d = pmbus_seq_pkg::SEQ_ON_DLY; // RULE5
						tmr.start = 1'b1;
						tmr.ms = pmbus_seq_pkg::l11_ms(on_dly_q,
							pmbus_seq_pkg::ON_DELAY_MAX_MS);
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q <= pmbus_seq_pkg::SEQ_OFF;
		end else begin
			st_q <= st_d;
		end
	end

	assign powered = st_q inside {pmbus_seq_pkg::SEQ_RISE, pmbus_seq_pkg::SEQ_ON,
		pmbus_seq_pkg::SEQ_OFF_DLY, pmbus_seq_pkg::SEQ_FALL};

	// ----------------------------------------------------------------
	// Latched status
	// ----------------------------------------------------------------
	logic [3:0] vout_q, iout_q, input_q;
	logic temp_q, vendor_q;
	logic [7:0] cml_q, cml_set;
	logic [3:0] clr4;
	logic rd_bad;

	assign clr4 = {4{i_clear_faults}};
	always_comb begin
		cml_set = '0;
		cml_set[pmbus_seq_pkg::CML_BAD_WRITE] = wr_ro; // RULE22
		cml_set[pmbus_seq_pkg::CML_BAD_CMD] = wr_bad || rd_bad;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			vout_q <= '0;
			iout_q <= '0;
			input_q <= '0;
			temp_q <= 1'b0;
			vendor_q <= 1'b0;
			cml_q <= '0;
		end else begin
			vout_q <= (vout_q & ~clr4) | mon[3:0]; // RULE19
			iout_q <= (iout_q & ~clr4) | mon[7:4]; // RULE20
			input_q <= (input_q & ~clr4) | mon[11:8]; // RULE21 RULE1
			temp_q <= (temp_q && !i_clear_faults) || mon[pmbus_seq_pkg::MON_TEMP]; // RULE23
			vendor_q <= (vendor_q && !i_clear_faults) || mon[pmbus_seq_pkg::MON_VENDOR];
			cml_q <= (cml_q & ~{8{i_clear_faults}}) | cml_set; // RULE22
		end
	end

	// ----------------------------------------------------------------
	// Register views and read port
	// ----------------------------------------------------------------
	logic [7:0] crit, vout_v, iout_v, input_v;
	logic [15:0] full;
	logic other;

	// Flag views reverse mon order (fault first at bit 0) into bits 7:4
	assign vout_v = {vout_q[0], vout_q[1], vout_q[2], vout_q[3], 4'h0}; // RULE19
	assign iout_v = {iout_q[0], iout_q[1], iout_q[2], iout_q[3], 4'h0}; // RULE20
	assign input_v = {input_q[0], input_q[1], input_q[2], input_q[3], 4'h0}; // RULE21
	assign other = |input_v[7:5] || |vout_v[6:4] || |iout_v[6:4]; // RULE1
	assign crit = {1'b0, !powered, vout_v[7], iout_v[7], input_v[4], temp_q,
		|cml_q, other}; // RULE14 RULE15
	assign full = {|vout_v, |iout_v, |input_v, vendor_q, !good_q, 3'b000,
		crit}; // RULE16 RULE17 RULE23

	logic [15:0] rdata_q;
	logic rd_valid_q, alert_q;

	assign rd_bad = i_rd && !(i_cmd inside {pmbus_seq_pkg::CMD_IN_LOW_WARN,
		pmbus_seq_pkg::CMD_IN_LOW_FAULT, pmbus_seq_pkg::CMD_IN_LOW_ACTION,
		pmbus_seq_pkg::CMD_GOOD_ON, pmbus_seq_pkg::CMD_ON_DELAY, pmbus_seq_pkg::CMD_ON_RAMP,
		pmbus_seq_pkg::CMD_OFF_DELAY, pmbus_seq_pkg::CMD_OFF_RAMP,
		pmbus_seq_pkg::CMD_CRIT_SUMMARY, pmbus_seq_pkg::CMD_FULL_SUMMARY,
		pmbus_seq_pkg::CMD_VOUT_FLAGS, pmbus_seq_pkg::CMD_IOUT_FLAGS,
		pmbus_seq_pkg::CMD_INPUT_FLAGS, pmbus_seq_pkg::CMD_CML_FLAGS});

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_q <= '0;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= i_rd;
			if (i_rd) begin
				unique case (i_cmd)
					pmbus_seq_pkg::CMD_IN_LOW_WARN: rdata_q <= warn_q;
					pmbus_seq_pkg::CMD_IN_LOW_FAULT: rdata_q <= fault_q;
					pmbus_seq_pkg::CMD_IN_LOW_ACTION: rdata_q <= {8'h00,
						pmbus_seq_pkg::ACTION_RSVD, action_q}; // RULE5
					pmbus_seq_pkg::CMD_GOOD_ON: rdata_q <= good_on_q;
					pmbus_seq_pkg::CMD_ON_DELAY: rdata_q <= on_dly_q;
					pmbus_seq_pkg::CMD_ON_RAMP: rdata_q <= on_ramp_q;
					pmbus_seq_pkg::CMD_OFF_DELAY: rdata_q <= off_dly_q;
					pmbus_seq_pkg::CMD_OFF_RAMP: rdata_q <= off_ramp_q;
					pmbus_seq_pkg::CMD_CRIT_SUMMARY: rdata_q <= {8'h00, crit}; // RULE14
					pmbus_seq_pkg::CMD_FULL_SUMMARY: rdata_q <= full; // RULE16
					pmbus_seq_pkg::CMD_VOUT_FLAGS: rdata_q <= {8'h00, vout_v};
					pmbus_seq_pkg::CMD_IOUT_FLAGS: rdata_q <= {8'h00, iout_v};
					pmbus_seq_pkg::CMD_INPUT_FLAGS: rdata_q <= {8'h00, input_v};
					pmbus_seq_pkg::CMD_CML_FLAGS: rdata_q <= {8'h00, cml_q};
					default: rdata_q <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= |vout_q || |iout_q || |input_q || temp_q || vendor_q || |cml_q; // RULE1
		end
	end

	assign o_rdata = rdata_q;
	assign o_rd_valid = rd_valid_q;
	assign o_power_stage_on = powered;
	assign o_ramp_up = (st_q == pmbus_seq_pkg::SEQ_RISE);
	assign o_ramp_down = (st_q == pmbus_seq_pkg::SEQ_FALL);
	assign o_power_good = good_q;
	assign o_alert = alert_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	property p_warn_flags;
		mon[pmbus_seq_pkg::MON_VIN_BELOW_WARN] |=> input_v[5] && full[13] && crit[0] ##1 o_alert;
	endproperty
	a_warn_flags: assert property (p_warn_flags) else $error("warn flags not set"); // RULE1
	property p_uv_hold;
		uv_hold_q && mon[pmbus_seq_pkg::MON_VIN_BELOW_WARN] |=> uv_hold_q;
	endproperty
	a_uv_hold: assert property (p_uv_hold) else $error("uv fault released early"); // RULE2
	property p_action_read;
		i_rd && i_cmd == pmbus_seq_pkg::CMD_IN_LOW_ACTION |=> o_rdata[7:6] == 2'b10;
	endproperty
	a_action_read: assert property (p_action_read) else $error("action bits 7:6 wrong"); // RULE5
	property p_retry_time;
		st_q != pmbus_seq_pkg::SEQ_RETRY ##1 st_q == pmbus_seq_pkg::SEQ_RETRY
			|-> $past(tmr.ms) == 16'(({13'd0, $past(action_q[2:0])} + 16'd1) * 16'd35);
	endproperty
	a_retry_time: assert property (p_retry_time) else $error("retry delay wrong"); // RULE6
	property p_good_hold;
		good_q && !mon[pmbus_seq_pkg::MON_VOUT_BELOW_UVF] |=> good_q;
	endproperty
	a_good_hold: assert property (p_good_hold) else $error("power good dropped"); // RULE8
	property p_rise_after_delay;
		st_q == pmbus_seq_pkg::SEQ_ON_DLY && tmr.done && en_s && !uv_trip
			|=> st_q == pmbus_seq_pkg::SEQ_RISE && o_ramp_up;
	endproperty
	a_rise_after_delay: assert property (p_rise_after_delay) else $error("no ramp"); // RULE11
	property p_off_bit;
		!o_power_stage_on |-> crit[6] && full[6];
	endproperty
	a_off_bit: assert property (p_off_bit) else $error("off bit clear"); // RULE15
	property p_good_bit;
		!o_power_good |-> full[11];
	endproperty
	a_good_bit: assert property (p_good_bit) else $error("word bit 11 clear"); // RULE17
	property p_ro_write;
		i_wr && i_cmd == pmbus_seq_pkg::CMD_CRIT_SUMMARY |=> cml_q[1] && $stable(warn_q);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write not flagged"); // RULE22
	property p_latched;
		vout_q[0] && !i_clear_faults |=> vout_q[0] ##0 full[15] && crit[5];
	endproperty
	a_latched: assert property (p_latched) else $error("fault flag lost"); // RULE23

	c_retry: cover property (st_q == pmbus_seq_pkg::SEQ_RETRY ##1 st_q == pmbus_seq_pkg::SEQ_ON_DLY);
	c_good: cover property (!good_q ##1 good_q);
	c_full_cycle: cover property (st_q == pmbus_seq_pkg::SEQ_FALL ##1 st_q == pmbus_seq_pkg::SEQ_OFF);
endmodule

// File: tb/pmbus_host_model.sv
// Host side model: one register read or write per call.
// Assumes the block's register port on the same clock.
`timescale 1ns/10ps
module pmbus_host_model (
	input wire logic i_mclk,
	input wire logic [15:0] i_rdata,
	input wire logic i_rd_valid,
	output logic [7:0] o_cmd,
	output logic o_wr,
	output logic [15:0] o_wdata,
	output logic o_rd
);
	initial begin
		o_cmd = 8'h00;
		o_wr = 1'b0;
		o_wdata = 16'h0000;
		o_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge i_mclk);
		o_cmd = c;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_mclk);
		o_wr = 1'b0;
		o_wdata = ~d;
	endtask
	// One read per call; callers read summaries and details in either order
	task automatic rd(input logic [7:0] c, output logic [15:0] v);
		@(negedge i_mclk);
		o_cmd = c;
		o_rd = 1'b1;
		@(negedge i_mclk);
		o_rd = 1'b0;
		v = i_rd_valid ? i_rdata : 16'hxxxx;
	endtask
endmodule

// File: tb/pmbus_fault_status_sequencing_regs_test.sv
// Self-checking bench for the command register block.
// Assumes MS_CYCLES of 4 and the host model on the register port.
`timescale 1ns/10ps
module pmbus_fault_status_sequencing_regs_test;
	logic i_mclk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_enable = 1'b0;
	logic [15:0] i_monitor = 16'h0000;
	logic i_clear_faults = 1'b0;
	logic [7:0] cmd;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic wr;
	logic rd;
	logic rd_valid;
	logic o_power_stage_on;
	logic o_ramp_up;
	logic o_ramp_down;
	logic o_power_good;
	logic o_alert;
	logic [2:0] sig;
	logic [7:0] tc [4] = '{8'h60, 8'h61, 8'h64, 8'h65};
	int failures = 0;
	int num_checks = 0;
	int n;
	assign sig = {o_ramp_down, o_ramp_up, o_power_stage_on};
	always #25 i_mclk = ~i_mclk;
	pmbus_fault_status_sequencing_regs #(.MS_CYCLES(4)) pmbus_fault_status_sequencing_regs_i (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_enable(i_enable), .i_monitor(i_monitor),
		.i_strap_uv_fault(16'hc8c8), .i_strap_vout(16'h1000), .i_cmd(cmd), .i_wr(wr),
		.i_wdata(wdata), .i_rd(rd), .i_clear_faults(i_clear_faults), .o_rdata(rdata),
		.o_rd_valid(rd_valid), .o_power_stage_on(o_power_stage_on), .o_ramp_up(o_ramp_up),
		.o_ramp_down(o_ramp_down), .o_power_good(o_power_good), .o_alert(o_alert)
	);
	pmbus_host_model pmbus_host_model_i (
		.i_mclk(i_mclk), .i_rdata(rdata), .i_rd_valid(rd_valid), .o_cmd(cmd), .o_wr(wr),
		.o_wdata(wdata), .o_rd(rd)
	);
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rc(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] v;
		pmbus_host_model_i.rd(c, v);
		check(v, e);
	endtask
	task automatic span(input int idx, input logic lvl, output int k);
		k = 0;
		while (sig[idx] === lvl && k < 400) begin
			@(negedge i_mclk);
			k++;
		end
	endtask
	task automatic clr();
		@(negedge i_mclk);
		i_clear_faults = 1'b1;
		@(negedge i_mclk);
		i_clear_faults = 1'b0;
		repeat (3) @(negedge i_mclk);
	endtask
	task automatic finish_test();
		if (failures == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rc(8'h58, 16'hc8dc);
		rc(8'h59, 16'hc8c8);
		rc(8'h5a, 16'h0080);
		rc(8'h5e, 16'h0e66);
		foreach (tc[i]) rc(tc[i], 16'hca80);
		rc(8'h78, 16'h0040);
		rc(8'h79, 16'h0840);
		rc(8'h7a, 16'h0000);
		rc(8'h7b, 16'h0000);
		rc(8'h7c, 16'h0000);
	endtask
	task automatic t_regs();
		pmbus_host_model_i.wr(8'h5a, 16'h003f);
		rc(8'h5a, 16'h00bf);
		pmbus_host_model_i.wr(8'h78, 16'hffff);
		rc(8'h78, 16'h0042);
		rc(8'h7e, 16'h0002);
		rc(8'h20, 16'h0000);
		rc(8'h7e, 16'h0082);
		clr();
	endtask
	task automatic t_flags();
		i_monitor = 16'h0400;
		repeat (5) @(negedge i_mclk);
		check(o_alert, 1'b1);
		i_monitor = 16'h0000;
		repeat (5) @(negedge i_mclk);
		rc(8'h79, 16'h2841);
		rc(8'h7c, 16'h0020);
		clr();
		check(o_alert, 1'b0);
		i_monitor = 16'h30ff;
		repeat (5) @(negedge i_mclk);
		i_monitor = 16'h0000;
		rc(8'h7a, 16'h00f0);
		rc(8'h7b, 16'h00f0);
		rc(8'h79, 16'hd875);
		clr();
	endtask
	task automatic t_seq();
		pmbus_host_model_i.wr(8'h60, 16'h0001);
		pmbus_host_model_i.wr(8'h61, 16'h0002);
		pmbus_host_model_i.wr(8'h64, 16'h0001);
		pmbus_host_model_i.wr(8'h65, 16'h0002);
		i_enable = 1'b1;
		span(0, 1'b0, n);
		check(n >= 5 && n <= 10, 1'b1);
		span(1, 1'b1, n);
		check(n >= 8 && n <= 10, 1'b1);
		rc(8'h79, 16'h0800);
		i_monitor = 16'h4000;
		repeat (5) @(negedge i_mclk);
		check(o_power_good, 1'b1);
		rc(8'h79, 16'h0000);
		i_monitor = 16'h0000;
		repeat (5) @(negedge i_mclk);
		check(o_power_good, 1'b1);
		i_monitor = 16'h8000;
		repeat (5) @(negedge i_mclk);
		check(o_power_good, 1'b0);
		i_monitor = 16'h0000;
		i_enable = 1'b0;
		span(2, 1'b0, n);
		check(n >= 5 && n <= 10, 1'b1);
		span(2, 1'b1, n);
		check(n >= 8 && n <= 10, 1'b1);
		rc(8'h78, 16'h0040);
		clr();
	endtask
	task automatic t_fault();
		pmbus_host_model_i.wr(8'h5a, 16'h0080);
		i_enable = 1'b1;
		span(0, 1'b0, n);
		repeat (12) @(negedge i_mclk);
		i_monitor = 16'h0c00;
		repeat (6) @(negedge i_mclk);
		check(o_power_stage_on, 1'b0);
		i_monitor = 16'h0400;
		repeat (30) @(negedge i_mclk);
		check(o_power_stage_on, 1'b0);
		i_monitor = 16'h0000;
		span(0, 1'b0, n);
		check(n < 20, 1'b1);
		repeat (12) @(negedge i_mclk);
		pmbus_host_model_i.wr(8'h5a, 16'h00b8);
		i_monitor = 16'h0800;
		repeat (4) @(negedge i_mclk);
		i_monitor = 16'h0000;
		span(0, 1'b1, n);
		span(0, 1'b0, n);
		check(n >= 140 && n <= 150, 1'b1);
		i_enable = 1'b0;
		clr();
	endtask
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(negedge i_mclk);
		i_reset_n = 1'b1;
		repeat (4) @(negedge i_mclk);
		t_reset();
		t_regs();
		t_flags();
		t_seq();
		t_fault();
		finish_test();
	end
	initial begin
		#(50 * 5000);
		failures++;
		finish_test();
	end
endmodule
